// *** hw/adc_mode_control.sv ***
// Converter mode register and successive approximation sequencer
//
// Operation
// - Mode register resets to zero.
// - Accepts bit writes and byte writes.
// - Run bit7, freq 5:3, range 2:1, comparator 0.
// - Run bit halts or performs conversions.
// - Comparator enable powers comparator on or off.
// - Two bits give four operating states.
// - Writes insert one wait cycle.
// - High range times 264 to 44 clocks.
// - Low range times 480 to 80 clocks.
module adc_mode_control
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [15:0] i_cpu_addr,
   input wire logic i_cpu_wr,
   input wire logic [7:0] i_cpu_wdata,
   input wire logic i_cpu_bit_wr,
   input wire logic [2:0] i_cpu_bit_sel,
   input wire logic i_cpu_bit_val,
   input wire logic i_cpu_rd,
   output logic [7:0] o_cpu_rdata,
   output logic o_cpu_wait,
   input wire logic i_comp_high,
   output logic o_comparator_on,
   output logic o_sample,
   output logic [9:0] o_sar_trial,
   output logic [9:0] o_result,
   output logic o_conv_done,
   output logic o_converting,
   output logic o_first_unreliable,
   output logic o_conv_tick
);
   typedef struct packed
   {
      logic [7:0] mode;
      logic [7:0] rdata;
      logic wait_cyc;
      adc_mode_pkg::conv_state_t state;
      logic [5:0] tcnt;
      logic [3:0] bidx;
      logic [9:0] sar;
      logic [9:0] result;
      logic done;
      logic sample;
      logic first_bad;
      logic [7:0] settle;
   } main_state_t;

   main_state_t st;
   main_state_t next_st;
   logic hit;
   logic run_ok;
   logic [2:0] freq;
   logic [1:0] range;
   logic [5:0] ticks;
   logic tick;

   // ==========================================================
   // Field decode of the stored mode
   // field layout
   assign freq = st.mode[adc_mode_pkg::FREQ_MSB:adc_mode_pkg::FREQ_LSB];
   assign range =
      st.mode[adc_mode_pkg::RANGE_MSB:adc_mode_pkg::RANGE_LSB];
   assign ticks = adc_mode_pkg::conv_ticks(range);
   assign hit = (i_cpu_addr == adc_mode_pkg::MODE_ADDR);
   assign run_ok = st.mode[adc_mode_pkg::RUN_BIT]
      && (freq <= adc_mode_pkg::FREQ_MAX)
      && (range <= adc_mode_pkg::RANGE_LOW);

   // ==========================================================
   // Conversion clock, free of the sequencer so timing stays exact
   conv_clock_div u_div
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_run(run_ok),
      .i_div(adc_mode_pkg::fad_divider(freq)),
      .o_tick(tick)
   );

   // ==========================================================
   // Register access, settle timer and sequencer
   always_comb
   begin
      next_st = st;
      next_st.wait_cyc = 1'b0;
      next_st.done = 1'b0;
      next_st.sample = 1'b0;
      next_st.rdata = 8'h00;
      if (hit && i_cpu_wr)
      begin
         next_st.mode = i_cpu_wdata;
      end
      else if (hit && i_cpu_bit_wr)
      begin
         next_st.mode[i_cpu_bit_sel] = i_cpu_bit_val;
      end
      next_st.mode[adc_mode_pkg::ZERO_BIT] = 1'b0;
      next_st.wait_cyc = hit && (i_cpu_wr || i_cpu_bit_wr);
      if (hit && i_cpu_rd)
      begin
         next_st.rdata = st.mode;
      end
      // Settling timer saturates; restarts when comparator is off
      if (!st.mode[adc_mode_pkg::CMP_BIT])
      begin
         next_st.settle = 8'h00;
      end
      else if (st.settle != adc_mode_pkg::SETTLE_CYCLES)
      begin
         next_st.settle = st.settle + 8'h01;
      end
      // Suspect flag covers only the first done pulse of a run
      if (st.done)
      begin
         next_st.first_bad = 1'b0;
      end
      if (!run_ok)
      begin
         next_st.state = adc_mode_pkg::ST_IDLE;
         next_st.tcnt = 6'h00;
         next_st.bidx = 4'h0;
      end
      else
      begin
         case (st.state)
            adc_mode_pkg::ST_IDLE:
            begin
               next_st.state = adc_mode_pkg::ST_SAMPLE;
               next_st.sample = 1'b1;
               next_st.tcnt = 6'h00;
               next_st.first_bad = !st.mode[adc_mode_pkg::CMP_BIT]
                  || (st.settle != adc_mode_pkg::SETTLE_CYCLES);
            end
            adc_mode_pkg::ST_SAMPLE:
            begin
               if (tick)
               begin
                  next_st.tcnt = st.tcnt + 6'h01;
                  if (st.tcnt == ticks - 6'(adc_mode_pkg::RESOLUTION + 1))
                  begin
                     next_st.state = adc_mode_pkg::ST_RESOLVE;
                     next_st.bidx = 4'(adc_mode_pkg::RESOLUTION - 1);
                     next_st.sar = adc_mode_pkg::TRIAL_MSB;
                  end
               end
            end
            adc_mode_pkg::ST_RESOLVE:
            begin
               if (tick)
               begin
                  // keep or drop trial bit, move down
                  if (!i_comp_high)
                  begin
                     next_st.sar[st.bidx] = 1'b0;
                  end
                  if (st.bidx == 4'h0)
                  begin
                     next_st.result = next_st.sar;
                     next_st.done = 1'b1;
                     next_st.sample = 1'b1;
                     next_st.state = adc_mode_pkg::ST_SAMPLE;
                     next_st.tcnt = 6'h00;
                  end
                  else
                  begin
                     next_st.bidx = st.bidx - 4'h1;
                     next_st.sar[st.bidx - 4'h1] = 1'b1;
                  end
               end
            end
            default:
            begin
               next_st.state = adc_mode_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st <= '0;
         st.mode <= adc_mode_pkg::MODE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // comparator power follows its bit
   assign o_comparator_on = st.mode[adc_mode_pkg::CMP_BIT];
   assign o_converting = (st.state != adc_mode_pkg::ST_IDLE);
   assign o_cpu_rdata = st.rdata;
   assign o_cpu_wait = st.wait_cyc;
   assign o_sample = st.sample;
   assign o_sar_trial = st.sar;
   assign o_result = st.result;
   assign o_conv_done = st.done;
   assign o_first_unreliable = st.first_bad;
   assign o_conv_tick = tick;

   // ==========================================================
   // Helper: cycles since the last sample pulse
   logic [9:0] gap;
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || o_sample)
      begin
         gap <= 10'h001;
      end
      else if (gap != 10'h3ff)
      begin
         gap <= gap + 10'h001;
      end
   end

   property p_reset_zero;
      @(posedge i_mclk) i_rst |=> (st.mode == 8'h00) && !o_converting;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("mode not cleared by reset");

   property p_byte_wr;
      @(posedge i_mclk) disable iff (i_rst)
      (hit && i_cpu_wr) |=> st.mode == {$past(i_cpu_wdata[7]), 1'b0,
         $past(i_cpu_wdata[5:0])};
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write not stored");

   property p_bit_wr;
      @(posedge i_mclk) disable iff (i_rst)
      (hit && i_cpu_bit_wr && !i_cpu_wr && i_cpu_bit_sel != 3'h6)
         |=> st.mode[$past(i_cpu_bit_sel)] == $past(i_cpu_bit_val);
   endproperty
   a_bit_wr: assert property (p_bit_wr)
      else $error("bit write not stored");

   property p_zero_bit;
      @(posedge i_mclk) disable iff (i_rst)
      (hit && i_cpu_rd) |=> o_cpu_rdata[6] == 1'b0;
   endproperty
   a_zero_bit: assert property (p_zero_bit)
      else $error("bit 6 reads one");

   property p_stop;
      @(posedge i_mclk) disable iff (i_rst)
      !st.mode[7] |=> !o_converting && !o_sample && !o_conv_done;
   endproperty
   a_stop: assert property (p_stop)
      else $error("conversion while run bit clear");

   property p_start;
      @(posedge i_mclk) disable iff (i_rst)
      (run_ok && !o_converting) |=> o_sample && o_converting;
   endproperty
   a_start: assert property (p_start)
      else $error("conversion did not start");

   property p_wait;
      @(posedge i_mclk) disable iff (i_rst)
      (hit && i_cpu_wr) ##1 !(hit && (i_cpu_wr || i_cpu_bit_wr))
         |-> o_cpu_wait ##1 !o_cpu_wait;
   endproperty
   a_wait: assert property (p_wait)
      else $error("write wait cycle wrong");

   property p_period;
      @(posedge i_mclk) disable iff (i_rst)
      (o_conv_done && $stable(st.mode[5:1]))
         |-> 32'(gap) == 32'(adc_mode_pkg::fad_divider(freq)) * 32'(ticks);
   endproperty
   a_period: assert property (p_period)
      else $error("conversion time wrong");

   property p_msb_first;
      @(posedge i_mclk) disable iff (i_rst)
      (st.state == adc_mode_pkg::ST_SAMPLE
         && next_st.state == adc_mode_pkg::ST_RESOLVE)
         |=> o_sar_trial == 10'h200;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("resolve did not start at MSB");
endmodule

// *** hw/adc_mode_pkg.sv ***
// Constants, types and helpers for the converter mode control block
package adc_mode_pkg;
   // ==========================================================
   // Register map
   localparam logic [15:0] MODE_ADDR = 16'hff28;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam int RUN_BIT = 7;
   localparam int ZERO_BIT = 6;
   localparam int FREQ_MSB = 5;
   localparam int FREQ_LSB = 3;
   localparam int RANGE_MSB = 2;
   localparam int RANGE_LSB = 1;
   localparam int CMP_BIT = 0;

   // ==========================================================
   // Field encodings
   localparam logic [2:0] FREQ_MAX = 3'h5;
   localparam logic [1:0] RANGE_HIGH = 2'h0;
   localparam logic [1:0] RANGE_LOW = 2'h1;

   // ==========================================================
   // Conversion timing, in conversion clock ticks
   localparam int RESOLUTION = 10;
   localparam logic [5:0] TICKS_HIGH = 6'h16;
   localparam logic [5:0] TICKS_LOW = 6'h28;
   localparam logic [9:0] TRIAL_MSB = 10'h200;

   // Comparator settling time
   localparam int CLK_NS = 8;
   localparam int SETTLE_NS = 1000;
   localparam logic [7:0] SETTLE_CYCLES =
      8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_RESOLVE = 2'b10
   } conv_state_t;

   // Peripheral clocks per conversion clock tick
   function automatic logic [3:0] fad_divider(input logic [2:0] freq);
      case (freq)
         3'h0: fad_divider = 4'hc;
         3'h1: fad_divider = 4'h8;
         3'h2: fad_divider = 4'h6;
         3'h3: fad_divider = 4'h4;
         3'h4: fad_divider = 4'h3;
         default: fad_divider = 4'h2;
      endcase
   endfunction

   // Conversion clock ticks per conversion
   function automatic logic [5:0] conv_ticks(input logic [1:0] range);
      conv_ticks = (range == RANGE_LOW) ? TICKS_LOW : TICKS_HIGH;
   endfunction
endpackage

// *** hw/conv_clock_div.sv ***
// Conversion clock tick generator from the peripheral clock
module conv_clock_div
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [3:0] i_div,
   output logic o_tick
);
   typedef struct packed
   {
      logic [3:0] cnt;
      logic tick;
   } div_state_t;

   div_state_t st;
   div_state_t next_st;

   // ==========================================================
   // Divider: restarts from zero whenever the run stops
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!i_run)
      begin
         next_st.cnt = 4'h0;
      end
      else if (st.cnt == i_div - 4'h1)
      begin
         next_st.cnt = 4'h0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + 4'h1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_tick = st.tick;

   // ==========================================================
   // tick spacing check
   property p_tick_spacing;
      @(posedge i_mclk) disable iff (i_rst)
      (o_tick && i_run && i_div == 4'h3)
         ##1 (i_run && i_div == 4'h3)[*2]
         |-> (!o_tick && !$past(o_tick)) ##1 o_tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("conversion clock spacing wrong");
endmodule

// *** tb/sar_core_model.sv ***
// Behavioural analog core: sample-hold and voltage comparator
module sar_core_model
(
   input wire logic i_mclk,
   input wire logic i_sample,
   input wire logic i_comparator_on,
   input wire logic [9:0] i_trial,
   input wire logic [9:0] i_level,
   output logic o_comp_high
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [9:0] held = 10'h000;
   logic noise = 1'b0;

   // ==========================================================
   // Sample-hold
   // sample then hold
   always @(posedge i_mclk)
   begin
      noise <= ~noise;
      if (i_sample)
         held <= i_level;
   end

   // ==========================================================
   // Comparator; unpowered it answers with a toggling pattern
   // comparator power
   // ideal core, settles within any legal conversion clock
   always_comb
      o_comp_high = i_comparator_on ? (held >= i_trial) : noise;
endmodule

// *** tb/test_adc_mode_control.sv ***
// Self-checking bench for the converter mode control block
module test_adc_mode_control;
   timeunit 1ns;
   timeprecision 1ns;

   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] i_cpu_addr = adc_mode_pkg::MODE_ADDR;
   logic i_cpu_wr = 1'b0;
   logic [7:0] i_cpu_wdata = 8'h00;
   logic i_cpu_bit_wr = 1'b0;
   logic [2:0] i_cpu_bit_sel = 3'h0;
   logic i_cpu_bit_val = 1'b0;
   logic i_cpu_rd = 1'b0;
   logic [7:0] o_cpu_rdata;
   logic o_cpu_wait;
   logic comp_high;
   logic o_comparator_on;
   logic o_sample;
   logic o_conv_done;
   logic o_converting;
   logic o_first_unreliable;
   logic [9:0] o_sar_trial;
   logic [9:0] o_result;
   logic [9:0] level = 10'h000;
   int errors = 0;
   int n_tests = 0;
   int divs[6] = '{12, 8, 6, 4, 3, 2};
   int gap;
   int n_ticks;
   logic conv_tick;

   // ==========================================================
   // Clock, design and analog core
   always #4 i_mclk = ~i_mclk;

   adc_mode_control dut
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_cpu_addr(i_cpu_addr),
      .i_cpu_wr(i_cpu_wr),
      .i_cpu_wdata(i_cpu_wdata),
      .i_cpu_bit_wr(i_cpu_bit_wr),
      .i_cpu_bit_sel(i_cpu_bit_sel),
      .i_cpu_bit_val(i_cpu_bit_val),
      .i_cpu_rd(i_cpu_rd),
      .o_cpu_rdata(o_cpu_rdata),
      .o_cpu_wait(o_cpu_wait),
      .i_comp_high(comp_high),
      .o_comparator_on(o_comparator_on),
      .o_sample(o_sample),
      .o_sar_trial(o_sar_trial),
      .o_result(o_result),
      .o_conv_done(o_conv_done),
      .o_converting(o_converting),
      .o_first_unreliable(o_first_unreliable),
      .o_conv_tick(conv_tick)
   );

   sar_core_model core
   (
      .i_mclk(i_mclk),
      .i_sample(o_sample),
      .i_comparator_on(o_comparator_on),
      .i_trial(o_sar_trial),
      .i_level(level),
      .o_comp_high(comp_high)
   );

   // ==========================================================
   // Report and compare
   task automatic wrap_up();
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // ==========================================================
   // Register access; inputs move 1 ns after the edge
   // Each call ends one idle edge later, so no strobe flips twice at once
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   task automatic wr_byte(input logic [15:0] addr, input logic [7:0] data);
      i_cpu_addr = addr;
      i_cpu_wdata = data;
      i_cpu_wr = 1'b1;
      step(1);
      i_cpu_wr = 1'b0;
      i_cpu_addr = adc_mode_pkg::MODE_ADDR;
      check("write wait", {15'h0, addr == adc_mode_pkg::MODE_ADDR},
            {15'h0, o_cpu_wait});
      step(1);
   endtask

   task automatic wr_bit(input logic [2:0] sel, input logic val);
      i_cpu_bit_sel = sel;
      i_cpu_bit_val = val;
      i_cpu_bit_wr = 1'b1;
      step(1);
      i_cpu_bit_wr = 1'b0;
      check("bit write wait", 16'h1, {15'h0, o_cpu_wait});
      step(1);
   endtask

   task automatic rd_check(input logic [7:0] exp);
      i_cpu_rd = 1'b1;
      step(1);
      i_cpu_rd = 1'b0;
      check("mode read", {8'h0, exp}, {8'h0, o_cpu_rdata});
      step(1);
   endtask

   // Bounded wait for the next done pulse, counting cycles
   task automatic wait_done(output int n);
      n = 0;
      n_ticks = 0;
      do
      begin
         step(1);
         n++;
         if (conv_tick === 1'b1)
         begin
            n_ticks++;
         end
         if (n > 2000)
         begin
            errors++;
            wrap_up();
         end
      end
      while (o_conv_done !== 1'b1);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      step(12);
      i_rst = 1'b0;
      rd_check(8'h00);
      check("comparator idle", 16'h0, {15'h0, o_comparator_on});
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'hff);
      rd_check(8'hbf);
      step(30);
      check("prohibited idle", 16'h0, {15'h0, o_converting});
      wr_byte(16'hff29, 8'h00);
      rd_check(8'hbf);
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'h00);
      wr_bit(3'h0, 1'b1);
      check("comparator on", 16'h1, {15'h0, o_comparator_on});
      wr_bit(3'h6, 1'b1);
      rd_check(8'h01);
      // Frequency codes 0 to 5 in both ranges, settled comparator
      for (int r = 0; r < 2; r++)
         for (int f = 0; f < 6; f++)
         begin
            level = 10'(37 * (f + 6 * r) + 300);
            wr_byte(adc_mode_pkg::MODE_ADDR, {2'b00, 3'(f), 2'(r), 1'b1});
            step(130);
            wr_bit(3'h7, 1'b1);
            wait_done(gap);
            check("result", {6'h0, level}, {6'h0, o_result});
            check("sample at done", 16'h1, {15'h0, o_sample});
            check("first ok", 16'h0, {15'h0, o_first_unreliable});
            wait_done(gap);
            check("conv time", 16'(divs[f] * (r ? 40 : 22)),
                  16'(gap));
            check("conv ticks", 16'(r ? 40 : 22), 16'(n_ticks));
            wr_bit(3'h7, 1'b0);
            step(2);
            check("halted", 16'h0, {15'h0, o_converting});
            check("waiting mode", 16'h1, {15'h0, o_comparator_on});
         end
      // Run with the comparator off
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'ha8);
      wait_done(gap);
      check("off first", 16'h1, {15'h0, o_first_unreliable});
      check("off comparator", 16'h0, {15'h0, o_comparator_on});
      wait_done(gap);
      check("off second", 16'h0, {15'h0, o_first_unreliable});
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'h00);
      // Run started before the comparator settled
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'h29);
      wr_bit(3'h7, 1'b1);
      step(2);
      check("both set run", 16'h1, {15'h0, o_converting});
      wait_done(gap);
      check("early first", 16'h1, {15'h0, o_first_unreliable});
      wr_byte(adc_mode_pkg::MODE_ADDR, 8'h00);
      step(2);
      check("stopped", 16'h0, {15'h0, o_converting});
      wrap_up();
   end
endmodule
